// file: rtl/mpusfr_pkg.sv
// Package with the register map, reset values and carrier types of the special register bank.
package mpusfr_pkg;

  localparam int SFR_COUNT = 48;

  // Entry indices of registers that have a dedicated role in the bank.
  localparam int IDX_PORT0      = 0;
  localparam int IDX_STACK      = 1;
  localparam int IDX_PTR0_LOW   = 2;
  localparam int IDX_PTR0_HIGH  = 3;
  localparam int IDX_PTR1_LOW   = 4;
  localparam int IDX_PTR1_HIGH  = 5;
  localparam int IDX_STRETCH    = 13;
  localparam int IDX_PORT1      = 14;
  localparam int IDX_PTR_SELECT = 16;
  localparam int IDX_PORT2      = 26;
  localparam int IDX_PORT3      = 32;
  localparam int IDX_PAGE_HIGH  = 40;
  localparam int IDX_POLARITY   = 42;
  localparam int IDX_STATUS     = 43;
  localparam int IDX_BAUD       = 44;
  localparam int IDX_ACCUM      = 45;
  localparam int IDX_MULTIPLY   = 47;

  // Field positions.
  localparam int STATUS_BANK_LSB  = 3;
  localparam int STATUS_PARITY    = 0;
  localparam int PTR_SELECT_BIT   = 0;
  localparam int BAUD_CTRL_BIT    = 7;
  localparam int STRETCH_WIDTH    = 3;
  localparam logic [7:0] BIT_AREA_BASE = 8'h80;

  // Entry 47 stands first in each table, entry 0 last.
  localparam logic [SFR_COUNT-1:0][7:0] SFR_ADDR = {
    8'hf0, 8'he8, 8'he0, 8'hd8, 8'hd0, 8'hc8, 8'hc0, 8'hbf,
    8'hbb, 8'hba, 8'hb9, 8'hb8, 8'hb7, 8'hb6, 8'hb2, 8'hb0,
    8'haa, 8'ha9, 8'ha8, 8'ha2, 8'ha1, 8'ha0, 8'h9f, 8'h9e,
    8'h9d, 8'h9c, 8'h9b, 8'h9a, 8'h99, 8'h98, 8'h94, 8'h92,
    8'h91, 8'h90, 8'h8e, 8'h8d, 8'h8c, 8'h8b, 8'h8a, 8'h89,
    8'h88, 8'h87, 8'h85, 8'h84, 8'h83, 8'h82, 8'h81, 8'h80};

  localparam logic [SFR_COUNT-1:0][7:0] SFR_RESET = {
    {8{8'h00}},
    8'h03, 8'h03, {5{8'h00}}, 8'hff,
    8'hd9, {4{8'h00}}, 8'hff, 8'h00, 8'h00,
    {8{8'h00}},
    8'h00, 8'hff, 8'h01, {5{8'h00}},
    {6{8'h00}}, 8'h07, 8'hff};

  // Bits that hold storage; the others read as zero, except status bit 0, which reads the accumulator parity.
  localparam logic [SFR_COUNT-1:0][7:0] SFR_MASK = {
    8'hff, 8'hff, 8'hff, 8'h80, 8'hfe, 8'hff, 8'hff, 8'hff,
    {40{8'hff}}};

  typedef logic [SFR_COUNT-1:0][7:0] mpusfr_bank_t;
  typedef logic [3:0][7:0]           mpusfr_ports_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpusfr_req_s;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic       bit_data;
    logic [7:0] rdata;
  } mpusfr_rsp_s;

  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc_wdata;
    logic       mul_we;
    logic [7:0] mul_wdata;
    logic       stack_push;
    logic       stack_pop;
    logic       ptr_inc;
    logic       status_we;
    logic [7:0] status_wdata;
  } mpusfr_dp_s;

endpackage

// file: rtl/mpusfr_bank.sv
// Special function register bank of the microcontroller core: decode, storage and datapath roles.
//
// How it works
// - Unimplemented address reads return zero, unspecified.
// - Unimplemented address writes change nothing.
// - Bit access only on addresses ending 000.
// - Registers load listed reset values.
// - Baud control keeps only bit seven.
// - Accumulator written by datapath and address.
// - Multiply scratch shared by datapath and software.
// - Polarity register for two extra interrupts.
// - Page register gives high external address.
// - Stretch control resets to one cycle.
// - Pointer select bit picks active pointer.
// - Stack pointer pre-increments before each push.
// - Status bank bits pick working bank.
`timescale 1ns/1ps

module mpusfr_bank (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_n_in,
  input  wire mpusfr_pkg::mpusfr_req_s     core_req_in,
  input  wire mpusfr_pkg::mpusfr_dp_s      datapath_in,
  input  wire logic [mpusfr_pkg::SFR_COUNT-1:0] periph_we_in,
  input  wire mpusfr_pkg::mpusfr_bank_t    periph_wdata_in,
  input  wire mpusfr_pkg::mpusfr_ports_t   port_pins_in,
  output mpusfr_pkg::mpusfr_rsp_s          core_rsp_out,
  output mpusfr_pkg::mpusfr_bank_t         sfr_bank_out,
  output logic [mpusfr_pkg::SFR_COUNT-1:0] sfr_wr_pulse_out,
  output logic [7:0]                       accumulator_out,
  output logic [7:0]                       multiply_scratch_out,
  output logic [7:0]                       stack_pointer_out,
  output logic [15:0]                      data_pointer_first_out,
  output logic [15:0]                      data_pointer_second_out,
  output logic [15:0]                      active_data_ptr_out,
  output logic [1:0]                       bank_select_out,
  output logic [7:0]                       movx_page_high_out,
  output logic [2:0]                       memory_stretch_out,
  output logic [7:0]                       ext_irq_polarity_out,
  output logic                             baud_rate_ctrl_out
);
  import mpusfr_pkg::*;

  mpusfr_bank_t          regs;
  mpusfr_bank_t          next_regs;
  mpusfr_bank_t          merged;
  mpusfr_bank_t          read_view;
  mpusfr_bank_t          rd_term;
  mpusfr_bank_t          hw_val;
  mpusfr_ports_t         pins_meta;
  mpusfr_ports_t         pins_sync;
  mpusfr_rsp_s           next_rsp;
  mpusfr_rsp_s           rsp;
  logic [SFR_COUNT-1:0]  hit;
  logic [SFR_COUNT-1:0]  core_we;
  logic [SFR_COUNT-1:0]  hw_we;
  logic [SFR_COUNT-1:0]  wr_pulse;
  logic [15:0]           active_ptr;
  logic [15:0]           next_active_ptr;
  logic [15:0]           ptr_plus_one;
  logic [7:0]            rd_word;
  logic [7:0]            bit_onehot;
  logic [7:0]            sel_addr;
  logic                  ptr_sel;

  // Bit addresses of the special area name their byte by the upper five bits, so only
  // bytes whose low three address bits are zero can ever be reached bit-wise.
  assign sel_addr   = core_req_in.bit_mode ? {core_req_in.addr[7:3], 3'h0}
                                           : core_req_in.addr;
  assign bit_onehot = 8'h01 << core_req_in.addr[2:0];

  // Decode, merge and next-value selection, one copy per implemented register.
  // An unmatched address sets no hit bit, so no entry is written and nothing else moves.
  for (genvar i = 0; i < SFR_COUNT; i++) begin : g_entry
    assign hit[i]     = (sel_addr == SFR_ADDR[i]);
    assign core_we[i] = core_req_in.wr & hit[i];

    // A bit write folds into the stored latch value, never into the pin level, so a
    // read-modify-write on a port keeps the other seven outputs as they were.
    assign merged[i] = core_req_in.bit_mode
                     ? ((regs[i] & ~bit_onehot) |
                        ({8{core_req_in.wdata[0]}} & bit_onehot))
                     : core_req_in.wdata;

    // The instruction datapath wins over peripheral updates, and a peripheral update
    // wins over a software write, so a hardware event in the same cycle is not lost.
    assign next_regs[i] = (hw_we[i] ? hw_val[i]
                         : periph_we_in[i] ? periph_wdata_in[i]
                         : core_we[i] ? merged[i]
                         : regs[i]) & SFR_MASK[i];

    // Port reads see the synchronised pin, which still tracks an output pin.
    if (i == IDX_PORT0) begin : g_view_p0
      assign read_view[i] = pins_sync[0];
    end else if (i == IDX_PORT1) begin : g_view_p1
      assign read_view[i] = pins_sync[1];
    end else if (i == IDX_PORT2) begin : g_view_p2
      assign read_view[i] = pins_sync[2];
    end else if (i == IDX_PORT3) begin : g_view_p3
      assign read_view[i] = pins_sync[3];
    end else if (i == IDX_STATUS) begin : g_view_status
      // Parity is never stored; it follows the accumulator's even parity at all times.
      assign read_view[i] = {regs[i][7:1], ^regs[IDX_ACCUM]};
    end else begin : g_view_plain
      assign read_view[i] = regs[i];
    end

    assign rd_term[i] = hit[i] ? read_view[i] : 8'h00;
  end

  // At most one term is non-zero; an address that matches nothing returns zero, which
  // callers must treat as an arbitrary value.
  always_comb begin
    rd_word = 8'h00;
    for (int k = 0; k < SFR_COUNT; k++) begin
      rd_word = rd_word | rd_term[k];
    end
  end

  // Datapath side: the core works on these registers without a direct-address access.
  assign ptr_sel      = regs[IDX_PTR_SELECT][PTR_SELECT_BIT];
  assign ptr_plus_one = ptr_sel ? {regs[IDX_PTR1_HIGH], regs[IDX_PTR1_LOW]} + 16'h0001
                                : {regs[IDX_PTR0_HIGH], regs[IDX_PTR0_LOW]} + 16'h0001;

  always_comb begin
    hw_we  = '0;
    hw_val = regs;
    if (datapath_in.acc_we) begin
      hw_we[IDX_ACCUM]  = 1'b1;
      hw_val[IDX_ACCUM] = datapath_in.acc_wdata;
    end
    if (datapath_in.mul_we) begin
      hw_we[IDX_MULTIPLY]  = 1'b1;
      hw_val[IDX_MULTIPLY] = datapath_in.mul_wdata;
    end
    if (datapath_in.stack_push) begin
      hw_we[IDX_STACK]  = 1'b1;
      hw_val[IDX_STACK] = regs[IDX_STACK] + 8'h01;
    end else if (datapath_in.stack_pop) begin
      hw_we[IDX_STACK]  = 1'b1;
      hw_val[IDX_STACK] = regs[IDX_STACK] - 8'h01;
    end
    if (datapath_in.status_we) begin
      hw_we[IDX_STATUS]  = 1'b1;
      hw_val[IDX_STATUS] = datapath_in.status_wdata;
    end
    // Only the selected pointer counts; the other keeps its contents.
    if (datapath_in.ptr_inc && !ptr_sel) begin
      hw_we[IDX_PTR0_LOW]   = 1'b1;
      hw_we[IDX_PTR0_HIGH]  = 1'b1;
      hw_val[IDX_PTR0_LOW]  = ptr_plus_one[7:0];
      hw_val[IDX_PTR0_HIGH] = ptr_plus_one[15:8];
    end else if (datapath_in.ptr_inc) begin
      hw_we[IDX_PTR1_LOW]   = 1'b1;
      hw_we[IDX_PTR1_HIGH]  = 1'b1;
      hw_val[IDX_PTR1_LOW]  = ptr_plus_one[7:0];
      hw_val[IDX_PTR1_HIGH] = ptr_plus_one[15:8];
    end
  end

  // The active pointer is registered from next values so it never lags a select change.
  assign next_active_ptr = next_regs[IDX_PTR_SELECT][PTR_SELECT_BIT]
                         ? {next_regs[IDX_PTR1_HIGH], next_regs[IDX_PTR1_LOW]}
                         : {next_regs[IDX_PTR0_HIGH], next_regs[IDX_PTR0_LOW]};

  assign next_rsp.valid    = core_req_in.rd;
  assign next_rsp.hit      = core_req_in.rd & (|hit);
  assign next_rsp.rdata    = core_req_in.rd ? rd_word : 8'h00;
  assign next_rsp.bit_data = core_req_in.rd & core_req_in.bit_mode
                           & rd_word[core_req_in.addr[2:0]];

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regs <= SFR_RESET;
    end else begin
      regs <= next_regs;
    end
  end

  // Pins come from outside the clock domain and pass two flip-flops before any use.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= port_pins_in;
      pins_sync <= pins_meta;
    end
  end

  assign wr_pulse = core_we;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp        <= '0;
      active_ptr <= 16'h0000;
      sfr_wr_pulse_out <= '0;
    end else begin
      rsp        <= next_rsp;
      active_ptr <= next_active_ptr;
      sfr_wr_pulse_out <= wr_pulse;
    end
  end

  assign core_rsp_out            = rsp;
  assign sfr_bank_out            = regs;
  assign active_data_ptr_out     = active_ptr;
  assign accumulator_out         = regs[IDX_ACCUM];
  assign multiply_scratch_out    = regs[IDX_MULTIPLY];
  assign stack_pointer_out       = regs[IDX_STACK];
  assign data_pointer_first_out  = {regs[IDX_PTR0_HIGH], regs[IDX_PTR0_LOW]};
  assign data_pointer_second_out = {regs[IDX_PTR1_HIGH], regs[IDX_PTR1_LOW]};
  assign bank_select_out         = regs[IDX_STATUS][STATUS_BANK_LSB +: 2];
  assign movx_page_high_out      = regs[IDX_PAGE_HIGH];
  assign memory_stretch_out      = regs[IDX_STRETCH][STRETCH_WIDTH-1:0];
  assign ext_irq_polarity_out    = regs[IDX_POLARITY];
  assign baud_rate_ctrl_out      = regs[IDX_BAUD][BAUD_CTRL_BIT];

endmodule

// file: tb/mpusfr_bank_sva.sv
// Checker of the register bank port behaviour.
`timescale 1ns/1ps
module mpusfr_bank_sva (
  input wire logic                             clk_sys_in,
  input wire logic                             rst_n_in,
  input wire mpusfr_pkg::mpusfr_req_s          core_req_in,
  input wire mpusfr_pkg::mpusfr_dp_s           datapath_in,
  input wire mpusfr_pkg::mpusfr_rsp_s          core_rsp_out,
  input wire mpusfr_pkg::mpusfr_bank_t         sfr_bank_out,
  input wire logic [mpusfr_pkg::SFR_COUNT-1:0] sfr_wr_pulse_out,
  input wire logic [7:0]                       accumulator_out,
  input wire logic [7:0]                       stack_pointer_out,
  input wire logic [15:0]                      data_pointer_first_out,
  input wire logic [15:0]                      data_pointer_second_out,
  input wire logic [15:0]                      active_data_ptr_out,
  input wire logic [1:0]                       bank_select_out,
  input wire logic                             baud_rate_ctrl_out
);
  import mpusfr_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Bit addresses below the register page reach nothing.
  function automatic logic mapped(logic [7:0] a, logic b);
    logic [7:0] ba;
    ba = b ? {a[7:3], 3'h0} : a;
    mapped = 1'b0;
    for (int i = 0; i < SFR_COUNT; i++) begin
      mapped |= (SFR_ADDR[i] == ba) && a[7];
    end
  endfunction
  wire rd_miss = core_req_in.rd && !mapped(core_req_in.addr, core_req_in.bit_mode);
  wire wr_miss = core_req_in.wr && !mapped(core_req_in.addr, core_req_in.bit_mode);
  AST_VALID_TIMING: assert property (
    core_rsp_out.valid == $past(core_req_in.rd)) else $error("read answer timing wrong");
  AST_UNMAPPED_READ: assert property (
    rd_miss |=> !core_rsp_out.hit) else $error("unmapped read reported a hit");
  AST_UNMAPPED_WRITE: assert property (
    wr_miss |=> sfr_wr_pulse_out == '0) else $error("unmapped write pulsed a register");
  AST_BIT_READ: assert property (
    core_req_in.rd && core_req_in.bit_mode |=>
    core_rsp_out.bit_data == core_rsp_out.rdata[$past(core_req_in.addr[2:0])])
    else $error("bit read picked wrong bit");
  AST_ACC_DATAPATH: assert property (
    datapath_in.acc_we |=> accumulator_out == $past(datapath_in.acc_wdata))
    else $error("datapath accumulator write lost");
  AST_STACK_PUSH: assert property (
    datapath_in.stack_push |=> stack_pointer_out == 8'($past(stack_pointer_out) + 8'h01))
    else $error("stack pointer not incremented on push");
  AST_PTR_SELECT: assert property (
    active_data_ptr_out == (sfr_bank_out[IDX_PTR_SELECT][0] ?
    data_pointer_second_out : data_pointer_first_out)) else $error("active pointer wrong");
  AST_BANK_SELECT: assert property (
    bank_select_out == sfr_bank_out[IDX_STATUS][4:3]) else $error("bank select wrong");
  AST_BAUD_BIT: assert property (
    baud_rate_ctrl_out == sfr_bank_out[IDX_BAUD][7] && sfr_bank_out[IDX_BAUD][6:0] == 7'h00)
    else $error("baud control holds extra bits");
  cover property (core_req_in.wr && core_req_in.bit_mode);
  cover property (datapath_in.stack_push);
  cover property (rd_miss);
  cover property (datapath_in.ptr_inc);
endmodule

// file: tb/mpusfr_core_model.sv
// Behavioural core that issues register and datapath requests.
`timescale 1ns/1ps
module mpusfr_core_model (
  input  wire logic                    clk_sys_in,
  input  wire mpusfr_pkg::mpusfr_rsp_s rsp_in,
  output mpusfr_pkg::mpusfr_req_s      req_out,
  output mpusfr_pkg::mpusfr_dp_s       dp_out
);
  import mpusfr_pkg::*;
  initial begin
    req_out = '0;
    dp_out = '0;
  end
  // Each request is held for exactly one taking edge, then dropped.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge clk_sys_in);
    req_out <= '{rd: 1'b0, wr: 1'b1, bit_mode: b, addr: a, wdata: d};
    @(posedge clk_sys_in);
    req_out <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic b, output mpusfr_rsp_s r);
    @(posedge clk_sys_in);
    req_out <= '{rd: 1'b1, wr: 1'b0, bit_mode: b, addr: a, wdata: 8'h00};
    @(posedge clk_sys_in);
    req_out <= '0;
    #1;
    r = rsp_in;
  endtask
  task automatic strobe(input mpusfr_dp_s s);
    @(posedge clk_sys_in);
    dp_out <= s;
    @(posedge clk_sys_in);
    dp_out <= '0;
  endtask
endmodule

// file: tb/tb_mpusfr_special_register_bank.sv
// Self-checking bench of the register bank.
`timescale 1ns/1ps
module tb_mpusfr_special_register_bank;
  import mpusfr_pkg::*;
  logic                 clk_sys_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  mpusfr_req_s          req;
  mpusfr_dp_s           dp;
  mpusfr_rsp_s          rsp, r;
  mpusfr_bank_t         bank, snap;
  logic [7:0]           acc, mul, sp, page, pol;
  logic [15:0]          ptr0, ptr1, ptra;
  logic [1:0]           bsel;
  logic [2:0]           strch;
  logic                 baud;
  int                   error_cnt = 0;
  int                   total_checks = 0;
  logic [7:0] ra [12] = '{8'h81, 8'h8e, 8'haa, 8'hba, 8'hbb, 8'hc8, 8'hbf, 8'he0, 8'hf0,
                          8'h92, 8'hd8, 8'h90};
  logic [7:0] re [12] = '{8'h07, 8'h01, 8'hd9, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h5a};
  logic [7:0] wa [6] = '{8'he0, 8'hf0, 8'hbf, 8'hc8, 8'h8e, 8'ha1};
  logic [7:0] pa [5] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92};
  logic [7:0] pd [5] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h01};
  always #10 clk_sys_in = ~clk_sys_in;
  mpusfr_core_model core (.clk_sys_in(clk_sys_in), .rsp_in(rsp), .req_out(req), .dp_out(dp));
  mpusfr_bank dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .core_req_in(req),
    .datapath_in(dp), .periph_we_in('0), .periph_wdata_in('0), .port_pins_in({4{8'h5a}}),
    .core_rsp_out(rsp), .sfr_bank_out(bank), .sfr_wr_pulse_out(), .accumulator_out(acc),
    .multiply_scratch_out(mul), .stack_pointer_out(sp), .data_pointer_first_out(ptr0),
    .data_pointer_second_out(ptr1), .active_data_ptr_out(ptra), .bank_select_out(bsel),
    .movx_page_high_out(page), .memory_stretch_out(strch), .ext_irq_polarity_out(pol),
    .baud_rate_ctrl_out(baud));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    core.rd(a, 1'b0, r);
    chk("read answer", {22'h0, 2'b11, e}, {22'h0, r.valid, r.hit, r.rdata});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(negedge clk_sys_in);
    chk("port latches", 32'hffff_ffff, {bank[IDX_PORT3], bank[IDX_PORT2], bank[IDX_PORT1],
        bank[IDX_PORT0]});
    chk("stretch", 32'h1, {29'h0, strch});
    foreach (ra[i]) rchk(ra[i], re[i]);
    $display("reset test done");
    foreach (wa[i]) core.wr(wa[i], 8'h3c ^ wa[i], 1'b0);
    foreach (wa[i]) rchk(wa[i], 8'h3c ^ wa[i]);
    chk("role outputs", 32'hdccc_83f4, {acc, mul, page, pol});
    chk("stretch", 32'h2, {29'h0, strch});
    snap = bank;
    core.wr(8'h86, 8'ha5, 1'b0);
    core.wr(8'hf8, 8'ha5, 1'b0);
    @(negedge clk_sys_in);
    chk("bank unchanged", 32'h1, {31'h0, bank === snap});
    core.rd(8'hf8, 1'b0, r);
    chk("unmapped read", 32'h2, {30'h0, r.valid, r.hit});
    $display("byte test done");
    core.wr(8'he1, 8'h01, 1'b1);
    core.wr(8'he7, 8'h00, 1'b1);
    rchk(8'he0, 8'h5e);
    core.rd(8'he2, 1'b1, r);
    chk("bit read", 32'h1, {31'h0, r.bit_data});
    core.wr(8'hd8, 8'hff, 1'b0);
    rchk(8'hd8, 8'h80);
    chk("baud", 32'h1, {31'h0, baud});
    core.wr(8'hd0, 8'h18, 1'b0);
    core.wr(8'hd3, 8'h00, 1'b1);
    @(negedge clk_sys_in);
    chk("bank select", 32'h2, {30'h0, bsel});
    $display("bit test done");
    core.wr(8'h81, 8'h07, 1'b0);
    core.strobe('{stack_push: 1'b1, default: '0});
    @(negedge clk_sys_in);
    chk("stack", 32'h08, {24'h0, sp});
    core.strobe('{acc_we: 1'b1, acc_wdata: 8'h96, default: '0});
    rchk(8'he0, 8'h96);
    core.strobe('{mul_we: 1'b1, mul_wdata: 8'h69, default: '0});
    rchk(8'hf0, 8'h69);
    foreach (pa[i]) core.wr(pa[i], pd[i], 1'b0);
    @(negedge clk_sys_in);
    chk("pointers", 32'h5678_1234, {ptra, ptr0});
    core.wr(8'h92, 8'h00, 1'b0);
    @(negedge clk_sys_in);
    chk("pointers", 32'h1234_5678, {ptra, ptr1});
    core.strobe('{ptr_inc: 1'b1, default: '0});
    @(negedge clk_sys_in);
    chk("pointer increment", 32'h1235_5678, {ptr0, ptr1});
    core.strobe('{stack_pop: 1'b1, default: '0});
    @(negedge clk_sys_in);
    chk("stack pop", 32'h07, {24'h0, sp});
    $display("datapath test done");
    summarize();
  end
endmodule
bind mpusfr_bank mpusfr_bank_sva u_sva (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .core_req_in(core_req_in), .datapath_in(datapath_in), .core_rsp_out(core_rsp_out),
  .sfr_bank_out(sfr_bank_out), .sfr_wr_pulse_out(sfr_wr_pulse_out),
  .accumulator_out(accumulator_out), .stack_pointer_out(stack_pointer_out),
  .data_pointer_first_out(data_pointer_first_out),
  .data_pointer_second_out(data_pointer_second_out),
  .active_data_ptr_out(active_data_ptr_out), .bank_select_out(bank_select_out),
  .baud_rate_ctrl_out(baud_rate_ctrl_out));
